// *** hdl/cgt_clock_unit.sv ***
// Clock generation, domain gating, start-up delay and oscillator trim
`timescale 1ns/1ps
module cgt_clock_unit #(
  parameter int RESET_DLY_MID = cgt_pkg::RESET_DLY_MID_CYC,
  parameter int RESET_DLY_LONG = cgt_pkg::RESET_DLY_LONG_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] calibByte,
  input wire logic trimWrEn,
  input wire logic [7:0] trimWrData,
  output logic [7:0] fastOscTrim,
  input wire logic [1:0] startupDelaySelect,
  input wire logic [2:0] sleepMode,
  input wire logic twiClkEnable,
  input wire logic vadcEnable,
  input wire logic ccadcEnable,
  input wire logic wdtEnable,
  input wire logic bprotEnable,
  input wire logic ulpClkPin,
  input wire logic ccadcSrcPin,
  output logic coreDomainClock,
  output logic nvmIfaceClock,
  output logic periphDomainClock,
  output logic voltAdcClock,
  output logic chargeAdcClock,
  output logic serial2wDomainClock,
  output logic wdtBprotClock,
  output logic ulpOscEnable,
  output logic twiAddrWatchEnable,
  output logic extIntAsyncEnable,
  output logic coreRunning
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] trim;
    logic [15:0] ncoAcc;
    logic fastClk;
    logic divPhase;
    logic divClk;
    cgt_pkg::cgt_phase_e phase;
    logic [4:0] oscCnt;
    logic [cgt_pkg::DLY_W-1:0] dlyCnt;
    logic [1:0] sutSel;
    logic [2:0] modePrev;
  } cgt_unit_s;

  cgt_unit_s st_r;
  cgt_unit_s st_nxt;

  logic [1:0] sutSynced;
  logic ulpSynced;
  logic ccSynced;
  logic [cgt_pkg::NUM_DOM-1:0] srcNext;
  logic [cgt_pkg::NUM_DOM-1:0] gateReq;
  logic [cgt_pkg::NUM_DOM-1:0] gclk;
  logic [15:0] ncoInc;
  logic [16:0] ncoSum;
  logic fastRise;
  logic modeOff;
  logic protOn;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Selector defaults to code 10
  cgt_sync #(.W(2), .INIT(cgt_pkg::SUT_DEFAULT)) u_sutSync (
    .mclk(mclk),
    .rst(rst),
    .d(startupDelaySelect),
    .q(sutSynced)
  );

  cgt_sync #(.W(1), .INIT(1'b0)) u_ulpSync (
    .mclk(mclk),
    .rst(rst),
    .d(ulpClkPin),
    .q(ulpSynced)
  );

  cgt_sync #(.W(1), .INIT(1'b0)) u_ccSync (
    .mclk(mclk),
    .rst(rst),
    .d(ccadcSrcPin),
    .q(ccSynced)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Overlapping bands: upper band starts below the top of the lower one
  function automatic logic [7:0] trimEffective(input logic [7:0] t);
    if (t[cgt_pkg::TRIM_BAND_BIT]) begin
      trimEffective = {1'b0, t[6:0]} + cgt_pkg::BAND_OFFSET;
    end else begin
      trimEffective = {1'b0, t[6:0]};
    end
  endfunction

  function automatic logic isSleepDeep(input logic [2:0] m);
    isSleepDeep = (m == cgt_pkg::MODE_PSAVE) || (m == cgt_pkg::MODE_PDOWN);
  endfunction

  function automatic logic isAwake(input logic [2:0] m);
    isAwake = (m == cgt_pkg::MODE_ACTIVE) || (m == cgt_pkg::MODE_IDLE);
  endfunction

  // ----------------------------------------
  // Oscillator model
  // ----------------------------------------
  // Band bit picks range
  assign ncoInc = cgt_pkg::NCO_BASE + 16'(trimEffective(st_r.trim) * cgt_pkg::NCO_STEP);
  assign ncoSum = {1'b0, st_r.ncoAcc} + {1'b0, ncoInc};

  assign modeOff = (sleepMode == cgt_pkg::MODE_POFF);
  assign protOn = wdtEnable | bprotEnable;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.ncoAcc = ncoSum[15:0];
    st_nxt.fastClk = ncoSum[16] ? ~st_r.fastClk : st_r.fastClk;
    fastRise = ~st_r.fastClk & st_nxt.fastClk;
    st_nxt.modePrev = sleepMode;

    if (st_r.fastClk && !st_nxt.fastClk) begin
      st_nxt.divPhase = ~st_r.divPhase;
      if (st_r.divPhase) begin
        st_nxt.divClk = ~st_r.divClk;
      end
    end

    if (trimWrEn) begin
      st_nxt.trim = trimWrData;
    end

    case (st_r.phase)
      cgt_pkg::PH_LOAD: begin
        st_nxt.trim = calibByte;
        st_nxt.sutSel = sutSynced;
        st_nxt.oscCnt = '0;
        st_nxt.dlyCnt = '0;
        st_nxt.phase = cgt_pkg::PH_RST_OSC;
      end
      cgt_pkg::PH_RST_OSC: begin
        if (fastRise) begin
          st_nxt.oscCnt = st_r.oscCnt + 5'h01;
          if (st_r.oscCnt == cgt_pkg::RESET_OSC_CYCLES - 5'h01) begin
            st_nxt.oscCnt = '0;
            // Strap read late: at the load edge the synchroniser still holds its reset value
            st_nxt.sutSel = sutSynced;
            if (sutSynced == cgt_pkg::SUT_SHORT) begin
              st_nxt.phase = cgt_pkg::PH_RUN;
            end else begin
              st_nxt.phase = cgt_pkg::PH_RST_EXTRA;
            end
          end
        end
      end
      cgt_pkg::PH_RST_EXTRA: begin
        // Extra regulator delay; reserved code takes the long one
        st_nxt.dlyCnt = st_r.dlyCnt + 1'b1;
        if (st_r.sutSel == cgt_pkg::SUT_MID) begin
          if (st_r.dlyCnt == cgt_pkg::DLY_W'(RESET_DLY_MID - 1)) begin
            st_nxt.phase = cgt_pkg::PH_RUN;
          end
        end else if (st_r.dlyCnt == cgt_pkg::DLY_W'(RESET_DLY_LONG - 1)) begin
          st_nxt.phase = cgt_pkg::PH_RUN;
        end
      end
      cgt_pkg::PH_RUN: begin
        // Deep sleep exit waits for the oscillator
        if (isSleepDeep(st_r.modePrev) && isAwake(sleepMode)) begin
          st_nxt.oscCnt = '0;
          st_nxt.phase = cgt_pkg::PH_WAKE;
        end
      end
      cgt_pkg::PH_WAKE: begin
        if (fastRise) begin
          st_nxt.oscCnt = st_r.oscCnt + 5'h01;
          if (st_r.oscCnt == cgt_pkg::WAKE_OSC_CYCLES - 5'h01) begin
            st_nxt.oscCnt = '0;
            st_nxt.phase = cgt_pkg::PH_RUN;
          end
        end
      end
      default: begin
        st_nxt.phase = cgt_pkg::PH_LOAD;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r.trim <= 8'h00;
      st_r.ncoAcc <= 16'h0000;
      st_r.fastClk <= 1'b0;
      st_r.divPhase <= 1'b0;
      st_r.divClk <= 1'b0;
      st_r.phase <= cgt_pkg::PH_LOAD;
      st_r.oscCnt <= 5'h00;
      st_r.dlyCnt <= '0;
      st_r.sutSel <= cgt_pkg::SUT_DEFAULT;
      st_r.modePrev <= cgt_pkg::MODE_ACTIVE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Domain enables per sleep mode
  // ----------------------------------------
  always_comb begin
    gateReq = '0;
    case (sleepMode)
      cgt_pkg::MODE_ACTIVE: begin
        gateReq[cgt_pkg::DOM_CORE] = 1'b1;
        gateReq[cgt_pkg::DOM_NVM] = 1'b1;
        gateReq[cgt_pkg::DOM_PERIPH] = 1'b1;
        gateReq[cgt_pkg::DOM_VADC] = vadcEnable;
        gateReq[cgt_pkg::DOM_CHARGE] = ccadcEnable;
        gateReq[cgt_pkg::DOM_SERIAL] = twiClkEnable;
      end
      cgt_pkg::MODE_IDLE: begin
        // ADC keeps running with core halted
        gateReq[cgt_pkg::DOM_PERIPH] = 1'b1;
        gateReq[cgt_pkg::DOM_VADC] = vadcEnable;
        gateReq[cgt_pkg::DOM_CHARGE] = ccadcEnable;
        // Serial domain halts on its own
        gateReq[cgt_pkg::DOM_SERIAL] = twiClkEnable;
      end
      cgt_pkg::MODE_PSAVE: begin
        gateReq[cgt_pkg::DOM_CHARGE] = ccadcEnable;
      end
      default: begin
        gateReq = '0;
      end
    endcase
    // Watchdog domain in all but power-off
    gateReq[cgt_pkg::DOM_WDT] = protOn & ~modeOff;
    // Hold domains until start-up is over
    if (st_r.phase != cgt_pkg::PH_RUN) begin
      gateReq[cgt_pkg::DOM_WDT - 1:0] = '0;
      if (st_r.phase != cgt_pkg::PH_WAKE) begin
        gateReq[cgt_pkg::DOM_WDT] = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Gate sources and instances
  // ----------------------------------------
  always_comb begin
    srcNext = {cgt_pkg::NUM_DOM{st_nxt.divClk}};
    // Serial domain takes the undivided clock
    srcNext[cgt_pkg::DOM_SERIAL] = st_nxt.fastClk;
    srcNext[cgt_pkg::DOM_CHARGE] = ccSynced;
    srcNext[cgt_pkg::DOM_WDT] = ulpSynced;
  end

  cgt_gate_if gif[cgt_pkg::NUM_DOM] ();

  genvar gi;
  generate
    for (gi = 0; gi < cgt_pkg::NUM_DOM; gi++) begin : g_dom
      assign gif[gi].srcNext = srcNext[gi];
      assign gif[gi].enable = gateReq[gi];
      assign gclk[gi] = gif[gi].gatedClk;
      cgt_clk_gate u_gate (
        .mclk(mclk),
        .rst(rst),
        .gp(gif[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign coreDomainClock = gclk[cgt_pkg::DOM_CORE];
  assign nvmIfaceClock = gclk[cgt_pkg::DOM_NVM];
  assign periphDomainClock = gclk[cgt_pkg::DOM_PERIPH];
  assign voltAdcClock = gclk[cgt_pkg::DOM_VADC];
  assign chargeAdcClock = gclk[cgt_pkg::DOM_CHARGE];
  assign serial2wDomainClock = gclk[cgt_pkg::DOM_SERIAL];
  assign wdtBprotClock = gclk[cgt_pkg::DOM_WDT];
  assign fastOscTrim = st_r.trim;
  assign coreRunning = (st_r.phase == cgt_pkg::PH_RUN);

  // Low-power source on in reset and for protection outside power-off
  assign ulpOscEnable = rst | (st_r.phase == cgt_pkg::PH_LOAD)
      | (st_r.phase == cgt_pkg::PH_RST_OSC) | (st_r.phase == cgt_pkg::PH_RST_EXTRA)
      | (protOn & ~modeOff);

  // Address watch while serial clock is stopped
  assign twiAddrWatchEnable = ~modeOff & ~gateReq[cgt_pkg::DOM_SERIAL];

  assign extIntAsyncEnable = ~modeOff;

endmodule

// *** hdl/cgt_pkg.sv ***
// Shared constants, types and timing for the clock generation and trim unit
//
// Functional notes
// - The 4 MHz fast oscillator is divided to 1 MHz for the core, flash, peripheral and voltage ADC domains.
// - The two-wire serial domain gets the undivided clock and can be halted on its own.
// - With the serial clock halted, address watching stays on except in power-off.
// - Asynchronous external interrupt detection stays enabled except in power-off.
// - Gating the core clock stops all core activity.
// - The flash interface clock runs whenever the core clock runs.
// - The voltage ADC clock keeps running in idle while core and flash clocks halt.
// - The charge ADC clock stays on in power-save.
// - Watchdog and protection clock runs in every mode but power-off.
// - Unused domain clocks are stopped through the sleep mode.
// - Every reset copies the factory calibration byte into the trim register.
// - Wake from power-down or power-save waits 6 oscillator cycles.
// - Reset adds 14 cycles, plus 4.1 ms for code 01, plus 65 ms for code 10.
// - The start-up selector defaults to code 10.
// - Software reads and writes the trim byte; a write retunes at once.
// - Trim top bit selects the band; bands overlap so 0x7F beats 0x80.
// - Low seven trim bits tune monotonically, each step under 2 percent.
// - The ultra-low-power source is on with watchdog or protection outside power-off, and in reset.
package cgt_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    MODE_ACTIVE = 3'b000,
    MODE_IDLE = 3'b001,
    MODE_PSAVE = 3'b010,
    MODE_PDOWN = 3'b011,
    MODE_POFF = 3'b100
  } cgt_mode_e;

  typedef enum logic [2:0] {
    PH_LOAD = 3'b000,
    PH_RST_OSC = 3'b001,
    PH_RST_EXTRA = 3'b010,
    PH_RUN = 3'b011,
    PH_WAKE = 3'b100
  } cgt_phase_e;

  // ----------------------------------------
  // Start-up selector codes
  // ----------------------------------------
  localparam logic [1:0] SUT_SHORT = 2'h0;
  localparam logic [1:0] SUT_MID = 2'h1;
  localparam logic [1:0] SUT_LONG = 2'h2;
  localparam logic [1:0] SUT_DEFAULT = SUT_LONG;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam logic [4:0] WAKE_OSC_CYCLES = 5'h06;
  localparam logic [4:0] RESET_OSC_CYCLES = 5'h0e;
  localparam int RESET_DLY_MID_NS = 4_100_000;
  localparam int RESET_DLY_LONG_NS = 65_000_000;
  localparam int RESET_DLY_MID_CYC = (RESET_DLY_MID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_DLY_LONG_CYC = (RESET_DLY_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_W = 22;

  // ----------------------------------------
  // Oscillator model: phase step per mclk, toggle on carry
  // ----------------------------------------
  localparam logic [15:0] NCO_BASE = 16'h2933;
  localparam logic [15:0] NCO_STEP = 16'h0028;
  localparam logic [7:0] BAND_OFFSET = 8'h60;
  localparam int TRIM_BAND_BIT = 7;

  // ----------------------------------------
  // Domain indices
  // ----------------------------------------
  localparam int NUM_DOM = 7;
  localparam int DOM_CORE = 0;
  localparam int DOM_NVM = 1;
  localparam int DOM_PERIPH = 2;
  localparam int DOM_VADC = 3;
  localparam int DOM_CHARGE = 4;
  localparam int DOM_SERIAL = 5;
  localparam int DOM_WDT = 6;

endpackage

// *** hdl/cgt_gate_if.sv ***
// Link between the unit and one glitch-free clock gate
`timescale 1ns/1ps
interface cgt_gate_if;
  logic srcNext;
  logic enable;
  logic gatedClk;
  modport unit (output srcNext, output enable, input gatedClk);
  modport gate (input srcNext, input enable, output gatedClk);
endinterface

// *** hdl/cgt_sync.sv ***
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module cgt_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } cgt_sync_s;

  cgt_sync_s st_r;
  cgt_sync_s st_nxt;

  always_comb begin
    st_nxt.meta = d;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= {INIT, INIT};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.stable;
endmodule

// *** hdl/cgt_clk_gate.sv ***
// Glitch-free registered clock gate
`timescale 1ns/1ps
module cgt_clk_gate (
  input wire logic mclk,
  input wire logic rst,
  cgt_gate_if.gate gp
);
  typedef struct packed {
    logic en;
    logic clk;
  } cgt_gate_s;

  cgt_gate_s st_r;
  cgt_gate_s st_nxt;

  always_comb begin
    st_nxt.en = gp.srcNext ? st_r.en : gp.enable;
    st_nxt.clk = gp.srcNext & st_nxt.en;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign gp.gatedClk = st_r.clk;
endmodule

// *** tb/cgt_clock_props.sv ***
// Port checks for the clock generation and trim unit
`timescale 1ns/1ps
module cgt_clock_props #(
  parameter int RESET_DLY_MID = 20,
  parameter int RESET_DLY_LONG = 40
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] calibByte,
  input wire logic trimWrEn,
  input wire logic [7:0] trimWrData,
  input wire logic [7:0] fastOscTrim,
  input wire logic [2:0] sleepMode,
  input wire logic twiClkEnable,
  input wire logic wdtEnable,
  input wire logic bprotEnable,
  input wire logic coreDomainClock,
  input wire logic nvmIfaceClock,
  input wire logic periphDomainClock,
  input wire logic serial2wDomainClock,
  input wire logic wdtBprotClock,
  input wire logic ulpOscEnable,
  input wire logic twiAddrWatchEnable,
  input wire logic extIntAsyncEnable,
  input wire logic coreRunning
);
  // ----
  // Helper state
  // ----
  // Fast half period spans 3 to 7 mclk over the trim range, hence the slack
  localparam int LO_SLACK = 40;
  localparam int HI_SLACK = 240;
  logic seen_r;
  logic ever_r;
  int cnt_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seen_r <= 1'b0;
      ever_r <= 1'b0;
      cnt_r <= 0;
    end else begin
      seen_r <= 1'b1;
      ever_r <= ever_r | coreRunning;
      cnt_r <= ever_r ? cnt_r : cnt_r + 1;
    end
  end
  default clocking dcb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence serHigh;
    serial2wDomainClock [*3];
  endsequence
  sequence divHigh;
    coreDomainClock [*8];
  endsequence
  sequence holdLow;
    !coreRunning [*8];
  endsequence
  // ----
  // Assertions
  // ----
  trim_write_a: assert property (
    trimWrEn && seen_r |=> fastOscTrim == $past(trimWrData))
    else $error("trim readback wrong");
  trim_load_a: assert property (
    !seen_r |=> fastOscTrim == $past(calibByte))
    else $error("calibration not loaded");
  gate_hold_a: assert property (
    !ever_r && !coreRunning |-> !(coreDomainClock | nvmIfaceClock | periphDomainClock
      | serial2wDomainClock | wdtBprotClock))
    else $error("clock ran during start-up");
  start_delay_a: assert property (
    $rose(coreRunning) && !ever_r |->
      cnt_r inside {[RESET_DLY_LONG + LO_SLACK : RESET_DLY_LONG + HI_SLACK]})
    else $error("reset delay off");
  wake_hold_a: assert property (
    $fell(coreRunning) |-> holdLow)
    else $error("wake delay too short");
  serial_pulse_a: assert property (
    $rose(serial2wDomainClock) |-> serHigh)
    else $error("serial clock pulse cut");
  core_pulse_a: assert property (
    $rose(coreDomainClock) |-> divHigh)
    else $error("core clock not divided");
  nvm_follow_a: assert property (
    coreDomainClock |-> nvmIfaceClock)
    else $error("flash clock missing");
  ulp_on_a: assert property (
    (wdtEnable || bprotEnable) && sleepMode != cgt_pkg::MODE_POFF |-> ulpOscEnable)
    else $error("low power source off");
  int_async_a: assert property (
    extIntAsyncEnable == (sleepMode != cgt_pkg::MODE_POFF))
    else $error("async interrupt enable wrong");
  addr_watch_a: assert property (
    !twiClkEnable && sleepMode != cgt_pkg::MODE_POFF |-> twiAddrWatchEnable)
    else $error("address watch off");
endmodule

bind cgt_clock_unit cgt_clock_props #(
  .RESET_DLY_MID(RESET_DLY_MID),
  .RESET_DLY_LONG(RESET_DLY_LONG)
) props (.*);

// *** tb/cgt_domain_sink.sv ***
// Far-side model: pin clock sources and domain edge counters
`timescale 1ns/1ps
module cgt_domain_sink (
  input wire logic mclk,
  input wire logic ulpOscEnable,
  input wire logic [6:0] domClk,
  output logic ulpClkPin,
  output logic ccadcSrcPin,
  output int edgeCnt [7]
);
  // ----
  // Pin sources
  // ----
  // Slow source sped up so runs stay short
  logic [3:0] ph = 4'h0;
  initial begin
    ulpClkPin = 1'b0;
    ccadcSrcPin = 1'b0;
  end
  always @(negedge mclk) begin
    ph <= ph + 4'h1;
    ccadcSrcPin <= ph[2];
    ulpClkPin <= ulpOscEnable & ph[3];
  end
  // ----
  // Edge counters
  // ----
  for (genvar i = 0; i < 7; i++) begin : g_cnt
    always @(posedge domClk[i]) edgeCnt[i] <= edgeCnt[i] + 1;
  end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the clock generation and trim unit
`timescale 1ns/1ps
module tb_top;
  // ----
  // Signals
  // ----
  logic mclk, rst, trimWrEn, twiClkEnable, vadcEnable, ccadcEnable;
  logic wdtEnable, bprotEnable, ulpClkPin, ccadcSrcPin;
  logic [7:0] calibByte, trimWrData, fastOscTrim;
  logic [1:0] startupDelaySelect;
  logic [2:0] sleepMode;
  logic coreDomainClock, nvmIfaceClock, periphDomainClock, voltAdcClock;
  logic chargeAdcClock, serial2wDomainClock, wdtBprotClock;
  logic ulpOscEnable, twiAddrWatchEnable, extIntAsyncEnable, coreRunning;
  logic [6:0] dom;
  int edgeCnt [7];
  int snap [7];
  int d [7];
  int n_mismatch, check_count, k, fa, fb, fc;
  // Per sleep mode: domains judged, and which of them must toggle
  logic [2:0] modes [4] = '{3'h1, 3'h2, 3'h3, 3'h4};
  logic [6:0] care [4] = '{7'h4f, 7'h53, 7'h43, 7'h43};
  logic [6:0] runs [4] = '{7'h4c, 7'h50, 7'h40, 7'h00};

  cgt_clock_unit #(.RESET_DLY_MID(20), .RESET_DLY_LONG(40)) dut (.*);
  assign dom = {wdtBprotClock, serial2wDomainClock, chargeAdcClock, voltAdcClock,
    periphDomainClock, nvmIfaceClock, coreDomainClock};
  cgt_domain_sink sink (.mclk(mclk), .ulpOscEnable(ulpOscEnable), .domClk(dom),
    .ulpClkPin(ulpClkPin), .ccadcSrcPin(ccadcSrcPin), .edgeCnt(edgeCnt));

  // ----
  // Tasks
  // ----
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t trim %h not %h", $time, got, exp);
    end
  endtask
  task automatic cmpf(input logic ok);
    check_count++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %0t condition false", $time);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic span(input int n);
    snap = edgeCnt;
    cyc(n);
    foreach (d[i]) d[i] = edgeCnt[i] - snap[i];
  endtask
  task automatic wait_run();
    k = 0;
    while (coreRunning !== 1'b1 && k < 1000) begin
      cyc(1);
      k++;
    end
  endtask
  // Strobe is left high so back-to-back writes never drive it twice at once
  task automatic trim_wr(input logic [7:0] v);
    trimWrEn = 1'b1;
    trimWrData = v;
    cyc(1);
  endtask
  task automatic freq(input logic [7:0] v, output int f);
    trim_wr(v);
    trimWrEn = 1'b0;
    cmp8(fastOscTrim, v);
    cyc(10);
    span(2000);
    f = d[5];
  endtask
  task automatic wrap_up();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----
  // Clock and watchdog
  // ----
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    #(40_000 * 25);
    n_mismatch++;
    wrap_up();
  end

  // ----
  // Tests
  // ----
  initial begin
    rst = 1'b1;
    calibByte = 8'h40;
    trimWrEn = 1'b0;
    trimWrData = 8'h00;
    startupDelaySelect = 2'h2;
    sleepMode = 3'h0;
    twiClkEnable = 1'b1;
    vadcEnable = 1'b1;
    ccadcEnable = 1'b1;
    wdtEnable = 1'b1;
    bprotEnable = 1'b0;
    cyc(8);
    cmpf(ulpOscEnable);
    rst = 1'b0;
    cyc(2);
    cmp8(fastOscTrim, 8'h40);
    cmpf(dom === 7'h00 && coreRunning === 1'b0);
    wait_run();
    cmpf(coreRunning === 1'b1 && k >= 165 && k <= 185);
    span(2000);
    cmpf(d[0] > 0 && d[5] >= 4 * d[0] - 4 && d[5] <= 4 * d[0] + 4);
    cmpf(d[1] == d[0] && d[2] > 0 && d[4] > 0 && d[6] > 0);
    // No nonvolatile writes run here, so any trim value is allowed
    trim_wr(8'h7f);
    cmp8(fastOscTrim, 8'h7f);
    trim_wr(8'h80);
    trimWrEn = 1'b0;
    cmp8(fastOscTrim, 8'h80);
    freq(8'h7f, fa);
    freq(8'h80, fb);
    cmpf(fa > fb);
    freq(8'h00, fa);
    freq(8'h01, fb);
    freq(8'h10, fc);
    cmpf(fc > fa && (fb - fa) * 50 < fa);
    freq(8'h40, fa);
    twiClkEnable = 1'b0;
    cyc(20);
    span(200);
    cmpf(d[5] == 0 && d[0] > 0 && twiAddrWatchEnable === 1'b1);
    twiClkEnable = 1'b1;
    for (int m = 0; m < 4; m++) begin
      sleepMode = modes[m];
      cyc(40);
      span(400);
      foreach (d[i])
        if (care[m][i]) cmpf((d[i] > 0) == runs[m][i]);
      cmpf(extIntAsyncEnable === (m != 3));
      if (m == 1 || m == 2) begin
        sleepMode = 3'h0;
        cyc(2);
        cmpf(coreRunning === 1'b0);
        wait_run();
        cmpf(k >= 12 && k < 100);
      end
    end
    calibByte = 8'h55;
    wdtEnable = 1'b0;
    bprotEnable = 1'b1;
    sleepMode = 3'h0;
    startupDelaySelect = 2'h1;
    rst = 1'b1;
    cyc(3);
    cmpf(ulpOscEnable === 1'b1 && dom === 7'h00);
    rst = 1'b0;
    cyc(2);
    cmp8(fastOscTrim, 8'h55);
    wait_run();
    cmpf(coreRunning === 1'b1 && k >= 138 && k <= 156);
    span(400);
    cmpf(coreRunning === 1'b1 && d[6] > 0);
    wrap_up();
  end
endmodule
